//--- src/ars_sequencer.sv
/*
  auto-reclose sequencer with start routing, timers and delayed final-trip alarms.
  assumes all inputs synchronous to clk and settings expressed in ticks of the time base.
*/
// Function
// - reclaim expiry without new start returns sequencer to idle
// - low-set start reaches sequencer only with routing bit 0 set
// - routed high-set start with disabled enable blocks all reclosing
// - global enable arms reclosing; cleared, no cycle starts from idle
// - per-cycle enables for high-set start, phase trip, earth trip
// - breaker opens after per-source starting delay; zero opens at once
// - each cycle holds breaker closing for its dead time
// - settable reclaim time bounds wait for the next start
// - store command commits entered settings to active set
// - enables decide which cycles each source may start
// - cycles exhausted with fault persisting gives final trip, no close
// - final trip raises earth or phase alarm by its cause
// - with global enable set, alarms only on final trip or signalling-only earth trip; indicator and trip event still given
// - signalling-only earth use raises earth alarm on earth trip not routed to trip output; earth trips still start cycles
// - low-set earth start signals, alarm after operate time if routed off
// - infinite earth high-set setting removes its start and trip
// - output routing bits gate third signal and phase alarm paths
// - manual close starts reclaim, blocks reclosing; taken ahead of starts in idle, interlock not checked
// - up to five cycles; dead time 0.2 s minimum in 0.01 s steps
`timescale 1ns/1ps
module ars_sequencer #(
  parameter int TICK_CYCLES = ars_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire ars_pkg::ars_stage_t    stage,
  input  wire ars_pkg::ars_route_t    route,
  input  wire ars_pkg::ars_settings_t pendingSettings,
  input  wire logic                   storeSettingsCmd,
  input  wire logic                   blockInputOne,
  input  wire logic                   blockInputTwo,
  input  wire logic                   manualClose,
  input  wire logic                   interlockOk,
  output ars_pkg::ars_out_t           outputs
);
  import ars_pkg::*;

  typedef struct packed {
    ars_state_t    state;
    logic [CYC_W-1:0] cyc;
    logic [TW-1:0] timer;
    logic [31:0]   tickCnt;
    logic          causePh;
    logic          causeEf;
    logic          manualBlk;
    logic          tripSeen;
    ars_settings_t act;
    ars_out_t      out;
  } ars_core_t;

  ars_core_t q;
  ars_core_t d;

  // ==========================================================
  // start routing
  logic efHiStart, efHiTrip, ch1, ch2, ch3, anyStart, phTrip, efTrip, blockIn;
  logic [CYC_W-1:0] idx;
  logic okPh, okEf, okHs, hsBlock, canStart, tick;
  logic [TW-1:0] startDelay, deadSet;

  assign efHiStart = stage.efHighStart & ~route.efHighInfinite;
  assign efHiTrip  = stage.efHighTrip & ~route.efHighInfinite;
  assign ch2 = stage.phLowTrip | stage.phHighTrip
             | (stage.phLowStart & route.phaseStartSw[SWB_LOW_TO_CH2])
             | (stage.phHighStart & route.phaseStartSw[SWB_HIGH_TO_CH2]);
  assign ch3 = stage.efLowTrip | efHiTrip
             | (stage.efLowStart & route.earthStartSw[SWB_LOW_TO_CH2])
             | (efHiStart & route.earthStartSw[SWB_HIGH_TO_CH2]);
  assign ch1 = (stage.phHighStart & route.phaseStartSw[SWB_HIGH_TO_CH1])
             | (efHiStart & route.earthStartSw[SWB_HIGH_TO_CH1]);
  assign anyStart = ch1 | ch2 | ch3;
  assign phTrip   = stage.phLowTrip | stage.phHighTrip;
  assign efTrip   = stage.efLowTrip | efHiTrip;
  assign blockIn  = blockInputOne | blockInputTwo;

  assign idx      = (q.cyc < CYC_LAST) ? q.cyc : '0;
  assign okPh     = ch2 & q.act.phaseTripEn[idx];
  assign okEf     = ch3 & q.act.earthTripEn[idx];
  assign okHs     = ch1 & q.act.highsetEn[idx];
  assign hsBlock  = ch1 & ~q.act.highsetEn[idx];
  assign canStart = (q.cyc < CYC_LAST) & (okPh | okEf | okHs) & ~hsBlock;
  // earth delay applies only when the earth channel alone starts
  assign startDelay = (okPh | okHs) ? q.act.phaseDelay[idx] : q.act.earthDelay[idx];
  assign deadSet = (q.act.deadTime[idx] < DEAD_MIN_TICKS) ? DEAD_MIN_TICKS
                                                           : q.act.deadTime[idx];
  assign tick = (q.tickCnt == 32'(TICK_CYCLES - 1));

  // ==========================================================
  // next-state logic
  always_comb begin
    d = q;
    d.tickCnt  = tick ? '0 : q.tickCnt + 32'h1;
    d.tripSeen = phTrip | efTrip;
    if (storeSettingsCmd) begin
      d.act = pendingSettings;
    end
    case (q.state)
      ARS_IDLE: begin
        d.cyc = '0;
        if (manualClose) begin
          d.state     = ARS_RECLAIM;
          d.timer     = q.act.reclaimTime;
          d.manualBlk = 1'b1;
        end else if (q.act.globalEnable && anyStart) begin
          d.causePh = ch1 | ch2;
          d.causeEf = ch3;
          if (blockIn || hsBlock) begin
            d.state = ARS_FINAL;
          end else if (canStart) begin
            d.state = ARS_START;
            d.timer = startDelay;
          end
        end
      end
      ARS_START: begin
        if (blockIn || hsBlock) begin
          d.state = ARS_FINAL;
        end else if (!anyStart) begin
          d.state = (q.cyc == '0) ? ARS_IDLE : ARS_RECLAIM;
          d.timer = q.act.reclaimTime;
        end else if (q.timer == '0) begin
          if (interlockOk) begin
            d.state = ARS_OPEN;
          end
        end else if (tick) begin
          d.timer = q.timer - TW'(1);
        end
      end
      ARS_OPEN: begin
        d.state = ARS_DEAD;
        d.timer = deadSet;
      end
      ARS_DEAD: begin
        if (blockIn) begin
          d.state = ARS_FINAL;
        end else if (q.timer == '0) begin
          if (interlockOk) begin
            d.state = ARS_CLOSE;
          end
        end else if (tick) begin
          d.timer = q.timer - TW'(1);
        end
      end
      ARS_CLOSE: begin
        d.state = ARS_RECLAIM;
        d.timer = q.act.reclaimTime;
        d.cyc   = q.cyc + CYC_W'(1);
      end
      ARS_RECLAIM: begin
        if (anyStart) begin
          d.causePh = ch1 | ch2;
          d.causeEf = ch3;
          if (blockIn || q.manualBlk || !canStart) begin
            d.state = ARS_FINAL;
          end else begin
            d.state = ARS_START;
            d.timer = startDelay;
          end
        end else if (q.timer == '0) begin
          d.state     = ARS_IDLE;
          d.cyc       = '0;
          d.manualBlk = 1'b0;
        end else if (tick) begin
          d.timer = q.timer - TW'(1);
        end
      end
      ARS_FINAL: begin
        d.state = ARS_LOCKOUT;
      end
      ARS_LOCKOUT: begin
        if (manualClose) begin
          d.state     = ARS_RECLAIM;
          d.timer     = q.act.reclaimTime;
          d.cyc       = '0;
          d.manualBlk = 1'b1;
          d.causePh   = 1'b0;
          d.causeEf   = 1'b0;
        end
      end
      default: begin
        d.state = ARS_IDLE;
      end
    endcase
    d.out.cbOpen    = (d.state == ARS_OPEN) | (d.state == ARS_FINAL);
    d.out.cbClose   = (d.state == ARS_CLOSE);
    d.out.lockout   = (d.state == ARS_LOCKOUT);
    d.out.seqActive = (d.state != ARS_IDLE) & (d.state != ARS_LOCKOUT);
    d.out.tripOut   = phTrip | (efTrip & route.outputSw[OSW_EF_TO_TRIP]);
    // alarms by cause on final trip, on trips while globally disabled, earth alarm on signalling-only earth trip
    d.out.phaseAlarm = route.outputSw[OSW_TRIP_TO_PH]
                     & ((d.out.lockout & d.causePh) | (phTrip & ~d.act.globalEnable));
    d.out.earthAlarm = (d.out.lockout & d.causeEf)
                     | (efTrip & ~d.act.globalEnable)
                     | (efTrip & route.efSignalOnly & ~route.outputSw[OSW_EF_TO_TRIP]);
    d.out.signal3       = stage.phLowStart & route.outputSw[OSW_LOW_TO_SIG3];
    d.out.earthStartSig = stage.efLowStart;
    d.out.phaseOpInd = phTrip;
    d.out.earthOpInd = efTrip;
    d.out.tripEvent  = (phTrip | efTrip) & ~q.tripSeen;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign outputs = q.out;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_disabled_stays_idle: assert property (
    q.state == ARS_IDLE && !q.act.globalEnable && !manualClose && !storeSettingsCmd
    |=> q.state == ARS_IDLE) else $error("sequence left idle while disabled");
  a_open_after_delay: assert property (
    q.state == ARS_START && q.timer == '0 && interlockOk && anyStart && !blockIn && !hsBlock
    |=> q.out.cbOpen ##1 q.state == ARS_DEAD) else $error("open not issued after delay");
  a_close_after_dead: assert property (
    $rose(q.out.cbClose) |-> $past(q.state) == ARS_DEAD && $past(q.timer) == '0)
    else $error("close issued before dead time ended");
  a_reclaim_expiry_idle: assert property (
    q.state == ARS_RECLAIM && q.timer == '0 && !anyStart |=> q.state == ARS_IDLE)
    else $error("reclaim expiry did not return to idle");
  a_lockout_no_close: assert property (
    q.state == ARS_LOCKOUT |-> !q.out.cbClose) else $error("close during lockout");
  a_final_earth_alarm: assert property (
    $rose(q.state == ARS_LOCKOUT) && q.causeEf |-> q.out.earthAlarm)
    else $error("earth alarm missing on final trip");
  a_low_start_gate: assert property (
    !route.phaseStartSw[SWB_LOW_TO_CH2] && !phTrip && !stage.phHighStart |-> !ch2)
    else $error("low-set start reached sequencer");
  a_store_commits: assert property (
    storeSettingsCmd |=> q.act == $past(pendingSettings))
    else $error("settings not committed on store");
  a_block_final: assert property (
    q.state == ARS_DEAD && blockIn |=> q.state == ARS_FINAL ##1 q.state == ARS_LOCKOUT)
    else $error("block did not force final trip");
  a_interlock_open: assert property (
    q.state == ARS_START && !interlockOk |=> q.state != ARS_OPEN)
    else $error("breaker opened without interlock");
  a_cycle_bound: assert property (
    q.cyc <= CYC_LAST) else $error("cycle count beyond maximum");
  a_sig3_gate: assert property (
    !route.outputSw[OSW_LOW_TO_SIG3] |=> !q.out.signal3)
    else $error("third signal passed with routing bit clear");
  a_hs_infinite: assert property (
    route.efHighInfinite && !stage.efLowTrip |=> !q.out.earthOpInd)
    else $error("infinite earth high-set still tripping");
  a_final_phase_alarm: assert property (
    $rose(q.state == ARS_LOCKOUT) && q.causePh && $past(route.outputSw[OSW_TRIP_TO_PH])
    |-> q.out.phaseAlarm) else $error("phase alarm missing on final trip");
  a_no_mid_alarm: assert property (
    q.state != ARS_FINAL && q.state != ARS_LOCKOUT
    && q.act.globalEnable && !storeSettingsCmd |=> !q.out.phaseAlarm)
    else $error("phase alarm on intermediate trip");
  a_lockout_holds: assert property (
    q.state == ARS_LOCKOUT && !manualClose |=> q.state == ARS_LOCKOUT)
    else $error("restart out of lockout without manual close");
  a_trip_event_pulse: assert property (
    q.out.tripEvent |=> !q.out.tripEvent) else $error("trip event longer than one cycle");

  c_full_cycle:     cover property (q.state == ARS_CLOSE ##1 q.state == ARS_RECLAIM);
  c_final_trip:     cover property (q.state == ARS_FINAL ##1 q.state == ARS_LOCKOUT);
  c_reclaim_expire: cover property (q.state == ARS_RECLAIM ##1 q.state == ARS_IDLE);
  c_second_cycle:   cover property (q.state == ARS_START && q.cyc == CYC_W'(1));
  c_manual_reclaim: cover property (q.state == ARS_LOCKOUT && manualClose ##1 q.state == ARS_RECLAIM);
endmodule

//--- common/ars_pkg.sv
/*
  shared constants and carrier types of the auto-reclose sequencer.
  assumes a single 125 MHz clock and timer settings given in time-base ticks.
*/
package ars_pkg;
  // ==========================================================
  // timing
  localparam int CLK_KHZ         = 125000;             // clock rate in kHz
  localparam int TICK_MS         = 10;                 // time-base step in ms
  localparam int TICK_CYCLES_DEF = CLK_KHZ * TICK_MS;  // clocks per tick
  localparam int DEAD_MIN_MS     = 200;                // shortest dead time
  localparam int TW              = 16;                 // timer width in bits
  localparam logic [TW-1:0] DEAD_MIN_TICKS = TW'(DEAD_MIN_MS / TICK_MS);
  // ==========================================================
  // cycle count
  localparam int NCYC  = 5;                            // successive reclose cycles
  localparam int CYC_W = 3;
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(NCYC);
  // ==========================================================
  // routing switch bit positions
  localparam int SWB_LOW_TO_CH2  = 0;   // low-set start to trip channel
  localparam int SWB_HIGH_TO_CH2 = 1;   // high-set start to trip channel
  localparam int SWB_HIGH_TO_CH1 = 2;   // high-set start to high-set channel
  localparam int OSW_LOW_TO_SIG3 = 0;   // low-set phase start to third signal
  localparam int OSW_TRIP_TO_PH  = 1;   // phase trips to phase alarm
  localparam int OSW_EF_TO_TRIP  = 2;   // earth trip to trip output
  // ==========================================================
  // carriers
  typedef enum logic [2:0] {
    ARS_IDLE, ARS_START, ARS_OPEN, ARS_DEAD, ARS_CLOSE, ARS_RECLAIM, ARS_FINAL, ARS_LOCKOUT
  } ars_state_t;

  typedef struct packed {
    logic phLowStart;
    logic phHighStart;
    logic phLowTrip;
    logic phHighTrip;
    logic efLowStart;
    logic efHighStart;
    logic efLowTrip;
    logic efHighTrip;
  } ars_stage_t;

  typedef struct packed {
    logic                    globalEnable;
    logic [NCYC-1:0]         highsetEn;
    logic [NCYC-1:0]         phaseTripEn;
    logic [NCYC-1:0]         earthTripEn;
    logic [NCYC-1:0][TW-1:0] phaseDelay;
    logic [NCYC-1:0][TW-1:0] earthDelay;
    logic [NCYC-1:0][TW-1:0] deadTime;
    logic [TW-1:0]           reclaimTime;
  } ars_settings_t;

  typedef struct packed {
    logic [7:0] phaseStartSw;
    logic [7:0] earthStartSw;
    logic [7:0] outputSw;
    logic       efHighInfinite;
    logic       efSignalOnly;
  } ars_route_t;

  typedef struct packed {
    logic cbOpen;
    logic cbClose;
    logic tripOut;
    logic phaseAlarm;
    logic earthAlarm;
    logic signal3;
    logic earthStartSig;
    logic phaseOpInd;
    logic earthOpInd;
    logic tripEvent;
    logic seqActive;
    logic lockout;
  } ars_out_t;
endpackage

//--- tb/ars_partner.sv
/*
  breaker and earth-fault stage stand-in for the sequencer bench.
  assumes one clock and a fault level driven by the bench.
*/
`timescale 1ns/1ps
module ars_partner (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fault,
  input  wire logic cbOpen,
  input  wire logic cbClose,
  output logic      cbClosed,
  output logic      efTrip
);
  // ==========================================================
  // breaker position and earth stage trip
  // trip well inside reclaim
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cbClosed <= 1'b1;
      efTrip   <= 1'b0;
    end else begin
      if (cbOpen) cbClosed <= 1'b0;
      else if (cbClose) cbClosed <= 1'b1;
      efTrip <= fault && cbClosed && !cbOpen;  // trip clears once breaker opens
    end
  end
endmodule

//--- tb/ars_sequencer_bench.sv
/*
  self-checking bench for the auto-reclose sequencer.
  assumes the breaker stand-in ars_partner and a shortened time base.
*/
`timescale 1ns/1ps
module ars_sequencer_bench;
  import ars_pkg::*;
  localparam int TK = 4;  // clocks per tick
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          store = 1'b0;
  logic          fault = 1'b0;
  logic [1:0]    blk = 2'h0;
  logic          manCl = 1'b0;
  logic          ilk = 1'b1;
  logic          cbClosed;
  logic          efTrip;
  ars_stage_t    stg = '0;
  ars_stage_t    stgIn;
  ars_route_t    rt = '0;
  ars_settings_t pend = '0;
  ars_out_t      outputs;
  int            mismatches = 0;
  int            total_checks = 0;
  int            cyc = 0;
  int            nOpen = 0;
  int            nClose = 0;
  int            tOpen = 0;
  int            tClose = 0;
  // ==========================================================
  // design, partner and clock
  ars_sequencer #(.TICK_CYCLES(TK)) uut (
    .clk(clk), .rst_n(rst_n), .stage(stgIn), .route(rt), .pendingSettings(pend),
    .storeSettingsCmd(store), .blockInputOne(blk[0]), .blockInputTwo(blk[1]),
    .manualClose(manCl), .interlockOk(ilk), .outputs(outputs));
  ars_partner cb (
    .clk(clk), .rst_n(rst_n), .fault(fault), .cbOpen(outputs.cbOpen),
    .cbClose(outputs.cbClose), .cbClosed(cbClosed), .efTrip(efTrip));
  // earth trip comes from the stand-in
  always_comb begin
    stgIn = stg;
    stgIn.efLowTrip = efTrip;
  end
  initial forever #4 clk = ~clk;
  // breaker command counters and time stamps
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (outputs.cbOpen === 1'b1) begin
      nOpen <= nOpen + 1;
      tOpen <= cyc;
    end
    if (outputs.cbClose === 1'b1) begin
      nClose <= nClose + 1;
      tClose <= cyc;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic do_reset;
    @(posedge clk) rst_n <= 1'b0;
    stg <= '0;
    rt <= '0;
    fault <= 1'b0;
    blk <= 2'h0;
    manCl <= 1'b0;
    ilk <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rt.outputSw[OSW_TRIP_TO_PH] <= 1'b1;
    @(posedge clk);
  endtask
  // commits global enable, per-cycle earth and phase enables, dead times and reclaim time
  task automatic set_cfg(input logic ge, input logic [4:0] ee, input logic [4:0] pe);
    ars_settings_t s;
    s = '0;
    s.globalEnable = ge;
    s.earthTripEn = ee;
    s.phaseTripEn = pe;
    s.deadTime[0] = 16'h0014;
    s.deadTime[1] = 16'h0019;
    s.reclaimTime = 16'h001e;
    @(posedge clk) pend <= s;
    store <= 1'b1;
    @(posedge clk) store <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_persist;
    int o0, c0, t0, i;
    do_reset();
    set_cfg(1'b1, 5'h03, 5'h01);
    o0 = nOpen;
    c0 = nClose;
    @(posedge clk) fault <= 1'b1;
    t0 = cyc;
    for (i = 0; i < 50 && outputs.cbOpen !== 1'b1; i++) @(posedge clk);
    chk("openDelay", 32'(cyc - t0 <= 12), 1);
    for (i = 0; i < 200 && outputs.cbClose !== 1'b1; i++) @(posedge clk);
    #1;
    chk("deadTime", 32'(tClose - tOpen >= 80 && tClose - tOpen <= 92), 1);
    chk("midAlarm", outputs.earthAlarm, 0);
    for (i = 0; i < 1000 && outputs.lockout !== 1'b1; i++) @(posedge clk);
    repeat (200) @(posedge clk);
    chk("opens", nOpen - o0, 3);
    chk("closes", nClose - c0, 2);
    chk("efAlarm", outputs.earthAlarm, 1);
    chk("phAlarm", outputs.phaseAlarm, 0);
    chk("lockout", outputs.lockout, 1);
    fault <= 1'b0;
    $display("test persist done");
  endtask
  task automatic t_reclaim;
    int i, n;
    do_reset();
    set_cfg(1'b1, 5'h03, 5'h01);
    @(posedge clk) fault <= 1'b1;
    for (i = 0; i < 50 && outputs.cbOpen !== 1'b1; i++) @(posedge clk);
    fault <= 1'b0;
    for (i = 0; i < 200 && outputs.cbClose !== 1'b1; i++) @(posedge clk);
    for (n = 0; n < 400 && outputs.seqActive === 1'b1; n++) @(posedge clk);
    chk("reclaim", 32'(n >= 118 && n <= 132), 1);
    chk("idle", {outputs.seqActive, outputs.lockout}, 0);
    $display("test reclaim done");
  endtask
  task automatic t_disabled;
    int o0;
    do_reset();
    set_cfg(1'b0, 5'h03, 5'h01);
    o0 = nOpen;
    @(posedge clk) fault <= 1'b1;
    repeat (200) @(posedge clk);
    chk("noSeq", outputs.seqActive, 0);
    chk("noOpen", nOpen - o0, 0);
    chk("offAlarm", outputs.earthAlarm, 1);
    chk("efInd", outputs.earthOpInd, 1);
    chk("efNoTrip", outputs.tripOut, 0);
    fault <= 1'b0;
    $display("test disabled done");
  endtask
  task automatic t_route;
    int c0, i;
    do_reset();
    set_cfg(1'b1, 5'h00, 5'h01);
    c0 = nClose;
    rt.phaseStartSw[SWB_HIGH_TO_CH1] <= 1'b1;
    @(posedge clk) stg.phLowStart <= 1'b1;
    repeat (100) @(posedge clk);
    chk("lowStart", outputs.seqActive, 0);
    stg.phHighStart <= 1'b1;
    for (i = 0; i < 100 && outputs.lockout !== 1'b1; i++) @(posedge clk);
    #1;
    chk("hsBlock", outputs.lockout, 1);
    chk("hsClose", nClose - c0, 0);
    chk("hsNoEf", outputs.earthAlarm, 0);
    chk("hsPhAlarm", outputs.phaseAlarm, 1);
    @(posedge clk) rt.efSignalOnly <= 1'b1;
    stg.efHighTrip <= 1'b1;
    @(posedge clk) #1;
    chk("sigOnly", outputs.earthAlarm, 1);
    chk("noRestart", outputs.lockout, 1);
    $display("test route done");
  endtask
  task automatic t_signals;
    do_reset();
    set_cfg(1'b0, 5'h00, 5'h00);
    @(posedge clk) rt.outputSw[OSW_LOW_TO_SIG3] <= 1'b1;
    stg.phLowStart <= 1'b1;
    stg.efLowStart <= 1'b1;
    rt.efHighInfinite <= 1'b1;
    stg.efHighTrip <= 1'b1;
    @(posedge clk) #1;
    chk("sig3On", outputs.signal3, 1);
    chk("efStart", outputs.earthStartSig, 1);
    chk("efHiOff", outputs.earthOpInd, 0);
    @(posedge clk) rt.outputSw[OSW_LOW_TO_SIG3] <= 1'b0;
    rt.efHighInfinite <= 1'b0;
    stg.phLowTrip <= 1'b1;
    @(posedge clk) #1;
    chk("sig3Off", outputs.signal3, 0);
    chk("efHiOn", outputs.earthOpInd, 1);
    chk("phAlarmOn", outputs.phaseAlarm, 1);
    chk("phTripOut", outputs.tripOut, 1);
    chk("tripEvt", outputs.tripEvent, 1);
    @(posedge clk) rt.outputSw[OSW_TRIP_TO_PH] <= 1'b0;
    #1;
    chk("tripEvtEnd", outputs.tripEvent, 0);
    @(posedge clk) #1;
    chk("phAlarmOff", outputs.phaseAlarm, 0);
    chk("phInd", outputs.phaseOpInd, 1);
    $display("test signals done");
  endtask
  task automatic t_block;
    int o0, c0, i;
    do_reset();
    set_cfg(1'b1, 5'h03, 5'h01);
    o0 = nOpen;
    c0 = nClose;
    @(posedge clk) fault <= 1'b1;
    ilk <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk("ilkHold", nOpen - o0, 0);
    chk("ilkWait", outputs.seqActive, 1);
    @(posedge clk) ilk <= 1'b1;
    for (i = 0; i < 50 && outputs.cbOpen !== 1'b1; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    blk <= 2'h2;
    for (i = 0; i < 50 && outputs.lockout !== 1'b1; i++) @(posedge clk);
    #1;
    chk("blkFinal", outputs.lockout, 1);
    chk("blkOpens", nOpen - o0, 2);
    chk("blkCloses", nClose - c0, 0);
    @(posedge clk) blk <= 2'h0;
    fault <= 1'b0;
    manCl <= 1'b1;
    @(posedge clk) manCl <= 1'b0;
    stg.phLowTrip <= 1'b1;
    #1;
    chk("manReclaim", outputs.seqActive, 1);
    for (i = 0; i < 50 && outputs.lockout !== 1'b1; i++) @(posedge clk);
    #1;
    chk("manBlock", outputs.lockout, 1);
    chk("manCloses", nClose - c0, 0);
    chk("manPhAlarm", outputs.phaseAlarm, 1);
    $display("test block done");
  endtask
  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    t_persist();
    t_reclaim();
    t_disabled();
    t_route();
    t_signals();
    t_block();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
